// *** dv/sensor_sample_status_flags_tb_top.sv ***
`timescale 1ns/1ps
module sensor_sample_status_flags_tb_top
	import ssf_pkg::*;
;
	logic       clk = 0, rst_n = 0, pD = 0, tD = 0, go = 0, rem = 1, pEn = 1, tEn = 1, altimeter_select = 0;
	logic [7:0] ad = 8'h00, fSet = 8'h00, fStat = 8'h5a;
	logic       rdS, rdV, altM;
	logic [7:0] rdA, rdD, live;
	int         miscompares = 0, tests_run = 0;
	// Free-running 200 MHz clock
	initial forever #2.5 clk = ~clk;
	ssf_host_model u_host (.clk(clk), .go(go), .addr(ad), .readStrobe(rdS), .readAddr(rdA));
	ssf_status_flags u_dut (.clk(clk), .rst_n(rst_n), .pressDone(pD), .tempDone(tD),
		.readStrobe(rdS), .readAddr(rdA), .fifoSetup(fSet), .readyEventModeEnable(rem),
		.pressEventEnable(pEn), .tempEventEnable(tEn), .fifoStatus(fStat),
		.altimeterSelect(altimeter_select), .readData(rdD), .readValid(rdV), .liveSampleStatus(live),
		.altitudeMode(altM));
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
			miscompares++;
		end
	endtask
	// One host read through the partner, then compare the returned byte
	task rd(input logic [7:0] a, input logic [7:0] e);
		int i;
		@(posedge clk); go <= 1; ad <= a;
		@(posedge clk); go <= 0;
		for (i = 0; i < 4; i++) begin
			@(posedge clk); #1;
			if (rdV === 1'b1) break;
		end
		if (i == 4) begin
			miscompares++;
			tally_and_finish();
		end
		chk(e, rdD);
	endtask
	// Acquisition completion pulse; flags settle after the taking edge
	task ev(input logic p, input logic t);
		@(posedge clk); pD <= p; tD <= t;
		@(posedge clk); pD <= 0; tD <= 0; #1;
	endtask
	task t_reset;
		chk(8'h00, live);
		rd(ADDR_LIVE, 8'h00);
		$display("test reset done");
	endtask
	task t_press;
		ev(1, 0); chk(8'h0c, live);
		ev(1, 0); chk(8'hcc, live);
		rd(ADDR_ALIAS, 8'hcc);
		rd(ADDR_LIVE, 8'hcc); chk(8'hcc, live);
		rd(ADDR_FDATA, 8'h00); chk(8'hcc, live);
		rd(ADDR_PRESS_HI, 8'h00); chk(8'h00, live);
		$display("test pressure done");
	endtask
	task t_temp;
		ev(0, 1); chk(8'h0a, live);
		ev(0, 1); chk(8'haa, live);
		rd(ADDR_TEMP_HI, 8'h00); chk(8'h00, live);
		$display("test temperature done");
	endtask
	task t_enable;
		@(posedge clk); rem <= 0;
		ev(1, 1); chk(8'h06, live);
		rd(ADDR_PRESS_HI, 8'h00); rd(ADDR_TEMP_HI, 8'h00); chk(8'h00, live);
		@(posedge clk); rem <= 1; pEn <= 0; tEn <= 0;
		ev(1, 1); chk(8'h08, live);
		rd(ADDR_TEMP_HI, 8'h00); chk(8'h00, live);
		@(posedge clk); pEn <= 1; tEn <= 1;
		$display("test enables done");
	endtask
	task t_fifo;
		for (int m = 1; m < 3; m++) begin
			@(posedge clk); fSet <= 8'(m << FMODE_LO); altimeter_select <= m[0];
			ev(1, 1); chk(8'h0e, live);
			rd(ADDR_ALIAS, fStat);
			rd(ADDR_FSTAT, fStat);
			rd(ADDR_PRESS_HI, 8'h00); chk(8'h0e, live);
			rd(ADDR_FDATA, 8'h00); chk(8'h00, live);
			chk({7'h00, m[0]}, {7'h00, altM});
		end
		@(posedge clk); fSet <= 8'h00;
		$display("test fifo done");
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		t_reset();
		t_press();
		t_temp();
		t_enable();
		t_fifo();
		tally_and_finish();
	end
endmodule

// *** dv/ssf_host_model.sv ***
`timescale 1ns/1ps
module ssf_host_model (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [7:0] addr,
	output logic            readStrobe,
	output logic [7:0]      readAddr
);
	// One-cycle read request; released address toggles so nothing stale is held
	always_ff @(posedge clk) begin
		readStrobe <= go;
		readAddr   <= go ? addr : ~readAddr;
	end
endmodule

// *** logic/ssf_pkg.sv ***
// Summary of operation
// - Mode 00: address 00h returns live status
// - FIFO mode: address 00h returns FIFO status
// - Live status tracks every output register update
// - Bit 7 sets on any completion while bit 3 is set
// - Bit 7 clears on either high-byte read
// - FIFO mode: FIFO data read clears all flags
// - Bit 6 sets on pressure overwrite
// - Bit 6 clears on pressure high-byte read
// - Bit 5 sets on temperature overwrite
// - Bit 5 clears on temperature high-byte read
// - Bit 3 shows any new result ready
// - Bit 3 clears on either high-byte read
// - Bit 2 sets on new pressure result
// - Bit 2 clears on pressure high-byte read
// - Bit 1 sets on new temperature result
// - Bit 1 clears on temperature high-byte read
// - Combined flags need ready event mode enable
// - Pressure flags need pressure event enable
// - Temperature flags need temperature event enable
// - Bits 4, 0 reserved; read-only; reset zero
// - FIFO mode field bits 7:6 at 0Fh
// - Modes 01 and 10 both count as FIFO
package ssf_pkg;
	localparam logic [7:0] ADDR_ALIAS    = 8'h00;
	localparam logic [7:0] ADDR_PRESS_HI = 8'h01;
	localparam logic [7:0] ADDR_TEMP_HI  = 8'h04;
	localparam logic [7:0] ADDR_LIVE     = 8'h06;
	localparam logic [7:0] ADDR_FSTAT    = 8'h0d;
	localparam logic [7:0] ADDR_FDATA    = 8'h0e;
	localparam logic [7:0] ADDR_FSETUP   = 8'h0f;
	localparam int         BIT_ANY_OW    = 7;
	localparam int         BIT_PRESS_OW  = 6;
	localparam int         BIT_TEMP_OW   = 5;
	localparam int         BIT_ANY_RDY   = 3;
	localparam int         BIT_PRESS_RDY = 2;
	localparam int         BIT_TEMP_RDY  = 1;
	localparam int         FMODE_HI      = 7;
	localparam int         FMODE_LO      = 6;
	localparam logic [1:0] FMODE_OFF     = 2'h0;
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [7:0] STATUS_MASK   = 8'hee;
	localparam logic [7:0] READ_ZERO     = 8'h00;
endpackage

// *** logic/ssf_status_flags.sv ***
`timescale 1ns/1ps
module ssf_status_flags
	import ssf_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       pressDone,
	input  wire logic       tempDone,
	input  wire logic       readStrobe,
	input  wire logic [7:0] readAddr,
	input  wire logic [7:0] fifoSetup,
	input  wire logic       readyEventModeEnable,
	input  wire logic       pressEventEnable,
	input  wire logic       tempEventEnable,
	input  wire logic [7:0] fifoStatus,
	input  wire logic       altimeterSelect,
	output logic [7:0]      readData,
	output logic            readValid,
	output logic [7:0]      liveSampleStatus,
	output logic            altitudeMode
);
	typedef struct packed {
		logic [7:0] status;
		logic [7:0] rdata;
		logic       rvalid;
		logic       altMode;
	} ssf_state_t;

	ssf_state_t stateFf;
	ssf_state_t nxtState;
	logic       fifoOn;
	logic       pressClr;
	logic       tempClr;
	logic       anyClr;
	logic       pressOn;
	logic       tempOn;
	logic       anyOn;

	// Any nonzero mode (01 circular, 10 full stop) routes the FIFO
	assign fifoOn = fifoSetup[FMODE_HI:FMODE_LO] != FMODE_OFF;

	// Clear sources per flag group; status reads are not among them
	assign pressClr = readStrobe && (fifoOn ? readAddr == ADDR_FDATA
		: readAddr == ADDR_PRESS_HI);
	assign tempClr  = readStrobe && (fifoOn ? readAddr == ADDR_FDATA
		: readAddr == ADDR_TEMP_HI);
	assign anyClr   = pressClr || tempClr;
	assign pressOn  = pressDone && pressEventEnable;
	assign tempOn   = tempDone && tempEventEnable;

	// Combined flags follow either completion, gated only by the event mode
	assign anyOn    = readyEventModeEnable && (pressDone || tempDone);

	// Next state: set wins over clear in the same cycle
	always_comb begin
		nxtState = stateFf;
		nxtState.altMode = altimeterSelect;
		if (pressClr) begin
			nxtState.status[BIT_PRESS_OW] = 1'b0;
			nxtState.status[BIT_PRESS_RDY] = 1'b0;
		end
		if (tempClr) begin
			nxtState.status[BIT_TEMP_OW] = 1'b0;
			nxtState.status[BIT_TEMP_RDY] = 1'b0;
		end
		if (anyClr) begin
			nxtState.status[BIT_ANY_OW] = 1'b0;
			nxtState.status[BIT_ANY_RDY] = 1'b0;
		end
		// Per-sample updates in step with the output registers
		if (pressOn) begin
			nxtState.status[BIT_PRESS_OW] = stateFf.status[BIT_PRESS_RDY];
			nxtState.status[BIT_PRESS_RDY] = 1'b1;
		end
		if (tempOn) begin
			nxtState.status[BIT_TEMP_OW] = stateFf.status[BIT_TEMP_RDY];
			nxtState.status[BIT_TEMP_RDY] = 1'b1;
		end
		if (anyOn) begin
			if (stateFf.status[BIT_ANY_RDY]) begin
				nxtState.status[BIT_ANY_OW] = 1'b1;
			end
			nxtState.status[BIT_ANY_RDY] = 1'b1;
		end
		nxtState.status = nxtState.status & STATUS_MASK;
		// Read mux; alias follows FIFO mode
		nxtState.rvalid = readStrobe;
		nxtState.rdata = READ_ZERO;
		if (readStrobe) begin
			if (readAddr == ADDR_ALIAS) begin
				nxtState.rdata = fifoOn ? fifoStatus : stateFf.status;
			end else if (readAddr == ADDR_LIVE) begin
				nxtState.rdata = stateFf.status;
			end else if (readAddr == ADDR_FSTAT) begin
				nxtState.rdata = fifoStatus;
			end
		end
	end

	// Register the whole state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stateFf <= '{status: STATUS_RESET, rdata: READ_ZERO, rvalid: 1'b0,
				altMode: 1'b0};
		end else begin
			stateFf <= nxtState;
		end
	end

	assign readData         = stateFf.rdata;
	assign readValid        = stateFf.rvalid;
	assign liveSampleStatus = stateFf.status;
	assign altitudeMode     = stateFf.altMode;

	// Pressure completion after unread pressure result flags overwrite
	sequence s_pressAgain;
		pressOn && !pressClr && stateFf.status[BIT_PRESS_RDY];
	endsequence
	a_press_overwrite: assert property (@(posedge clk) disable iff (!rst_n)
		s_pressAgain |=> stateFf.status[BIT_PRESS_OW])
		else $error("pressure overwrite not flagged");
	a_temp_overwrite: assert property (@(posedge clk) disable iff (!rst_n)
		tempOn && stateFf.status[BIT_TEMP_RDY] |=> stateFf.status[BIT_TEMP_OW])
		else $error("temperature overwrite not flagged");
	a_press_ready: assert property (@(posedge clk) disable iff (!rst_n)
		pressOn |=> stateFf.status[BIT_PRESS_RDY])
		else $error("pressure ready not set");
	a_press_clear: assert property (@(posedge clk) disable iff (!rst_n)
		pressClr && !pressOn |=> !stateFf.status[BIT_PRESS_RDY])
		else $error("pressure ready not cleared");
	a_temp_clear: assert property (@(posedge clk) disable iff (!rst_n)
		tempClr && !tempOn |=> !stateFf.status[BIT_TEMP_RDY])
		else $error("temperature ready not cleared");
	a_press_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!pressEventEnable && !stateFf.status[BIT_PRESS_RDY]
		|=> !stateFf.status[BIT_PRESS_RDY])
		else $error("pressure flag set while disabled");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(stateFf.status & ~STATUS_MASK) == 8'h00)
		else $error("reserved status bit set");
	a_alias_live: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && readAddr == ADDR_ALIAS && !fifoOn
		|=> readValid && readData == $past(stateFf.status))
		else $error("alias did not return live status");
	a_alias_fifo: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && readAddr == ADDR_ALIAS && fifoOn
		|=> readData == $past(fifoStatus))
		else $error("alias did not return FIFO status");
	a_status_noclr: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && (readAddr == ADDR_ALIAS || readAddr == ADDR_LIVE)
		|=> (stateFf.status & $past(stateFf.status)) == $past(stateFf.status))
		else $error("status read cleared a flag");
	a_fifo_clear: assert property (@(posedge clk) disable iff (!rst_n)
		fifoOn && readStrobe && readAddr == ADDR_PRESS_HI && !pressOn
		|=> stateFf.status[BIT_PRESS_RDY] == $past(stateFf.status[BIT_PRESS_RDY]))
		else $error("high byte read cleared flag in FIFO mode");

	// Completion of either channel while the combined ready flag still stands
	sequence s_anyAgain;
		anyOn && stateFf.status[BIT_ANY_RDY];
	endsequence

	// Temperature completion while the previous result is unread
	sequence s_tempAgain;
		tempOn && !tempClr && stateFf.status[BIT_TEMP_RDY];
	endsequence

	// FIFO data read with no completion in the same cycle
	sequence s_fifoFlush;
		fifoOn && readStrobe && readAddr == ADDR_FDATA && !pressOn && !tempOn && !anyOn;
	endsequence

	// Temperature ready sets on an enabled completion
	a_temp_ready: assert property (@(posedge clk) disable iff (!rst_n)
		tempOn
		|=> stateFf.status[BIT_TEMP_RDY])
		else $error("temperature ready not set");

	// Combined ready sets on any completion
	a_any_ready: assert property (@(posedge clk) disable iff (!rst_n)
		anyOn
		|=> stateFf.status[BIT_ANY_RDY])
		else $error("combined ready not set");

	// Combined overwrite sets when a result lands on an unread one
	a_any_overwrite: assert property (@(posedge clk) disable iff (!rst_n)
		s_anyAgain
		|=> stateFf.status[BIT_ANY_OW])
		else $error("combined overwrite not flagged");

	// Temperature overwrite from the named sequence
	a_temp_again: assert property (@(posedge clk) disable iff (!rst_n)
		s_tempAgain
		|=> stateFf.status[BIT_TEMP_OW])
		else $error("temperature overwrite missed");

	// Combined ready clears on either high-byte read
	a_any_clear: assert property (@(posedge clk) disable iff (!rst_n)
		anyClr && !anyOn
		|=> !stateFf.status[BIT_ANY_RDY])
		else $error("combined ready not cleared");

	// Combined overwrite clears on either high-byte read
	a_any_owclear: assert property (@(posedge clk) disable iff (!rst_n)
		anyClr && !anyOn
		|=> !stateFf.status[BIT_ANY_OW])
		else $error("combined overwrite not cleared");

	// Pressure overwrite clears on its high-byte read
	a_press_owclear: assert property (@(posedge clk) disable iff (!rst_n)
		pressClr && !pressOn
		|=> !stateFf.status[BIT_PRESS_OW])
		else $error("pressure overwrite not cleared");

	// Temperature overwrite clears on its high-byte read
	a_temp_owclear: assert property (@(posedge clk) disable iff (!rst_n)
		tempClr && !tempOn
		|=> !stateFf.status[BIT_TEMP_OW])
		else $error("temperature overwrite not cleared");

	// No temperature ready while its event enable is low
	a_temp_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!tempEventEnable && !stateFf.status[BIT_TEMP_RDY]
		|=> !stateFf.status[BIT_TEMP_RDY])
		else $error("temperature flag set while disabled");

	// No temperature overwrite while its event enable is low
	a_temp_owgate: assert property (@(posedge clk) disable iff (!rst_n)
		!tempEventEnable && !stateFf.status[BIT_TEMP_OW]
		|=> !stateFf.status[BIT_TEMP_OW])
		else $error("temperature overwrite set while disabled");

	// No pressure overwrite while its event enable is low
	a_press_owgate: assert property (@(posedge clk) disable iff (!rst_n)
		!pressEventEnable && !stateFf.status[BIT_PRESS_OW]
		|=> !stateFf.status[BIT_PRESS_OW])
		else $error("pressure overwrite set while disabled");

	// No combined ready while the event mode is off
	a_any_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!readyEventModeEnable && !stateFf.status[BIT_ANY_RDY]
		|=> !stateFf.status[BIT_ANY_RDY])
		else $error("combined ready set while disabled");

	// No combined overwrite while the event mode is off
	a_any_owgate: assert property (@(posedge clk) disable iff (!rst_n)
		!readyEventModeEnable && !stateFf.status[BIT_ANY_OW]
		|=> !stateFf.status[BIT_ANY_OW])
		else $error("combined overwrite set while disabled");

	// Temperature high-byte read keeps flags in FIFO mode
	a_fifo_temphold: assert property (@(posedge clk) disable iff (!rst_n)
		fifoOn && readStrobe && readAddr == ADDR_TEMP_HI && stateFf.status[BIT_TEMP_RDY]
		|=> stateFf.status[BIT_TEMP_RDY])
		else $error("temperature byte read cleared flag in FIFO mode");

	// FIFO data read empties all six flags
	a_fifo_flush: assert property (@(posedge clk) disable iff (!rst_n)
		s_fifoFlush
		|=> stateFf.status == 8'h00)
		else $error("FIFO data read left a flag set");

	// FIFO data address is inert while the FIFO is off
	a_fdata_off: assert property (@(posedge clk) disable iff (!rst_n)
		!fifoOn && readStrobe && readAddr == ADDR_FDATA && stateFf.status[BIT_PRESS_RDY]
		|=> stateFf.status[BIT_PRESS_RDY])
		else $error("FIFO data read cleared flag with FIFO off");

	// Dedicated status address returns the live status
	a_live_read: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && readAddr == ADDR_LIVE
		|=> readData == $past(stateFf.status))
		else $error("live status read wrong");

	// FIFO status address returns the FIFO status
	a_fstat_read: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && readAddr == ADDR_FSTAT
		|=> readData == $past(fifoStatus))
		else $error("FIFO status read wrong");

	// Unmapped addresses read back zero
	a_other_zero: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe && readAddr != ADDR_ALIAS && readAddr != ADDR_LIVE
		&& readAddr != ADDR_FSTAT |=> readData == 8'h00)
		else $error("unmapped read not zero");

	// Read answer comes one cycle after the request
	a_valid_after: assert property (@(posedge clk) disable iff (!rst_n)
		readStrobe
		|=> readValid)
		else $error("read answer missing");

	// No answer without a request, and data returns to zero
	a_valid_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!readStrobe
		|=> !readValid && readData == 8'h00)
		else $error("spurious read answer");

	// Altitude mode mirrors the select one cycle late
	a_alt_mirror: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n
		|=> altitudeMode == $past(altimeterSelect))
		else $error("altitude mode not mirrored");

	// Pressure ready stands until its clear
	a_press_hold: assert property (@(posedge clk) disable iff (!rst_n)
		stateFf.status[BIT_PRESS_RDY] && !pressClr
		|=> stateFf.status[BIT_PRESS_RDY])
		else $error("pressure ready dropped");

	// Temperature ready stands until its clear
	a_temp_hold: assert property (@(posedge clk) disable iff (!rst_n)
		stateFf.status[BIT_TEMP_RDY] && !tempClr
		|=> stateFf.status[BIT_TEMP_RDY])
		else $error("temperature ready dropped");
endmodule
